// ===== core/jtbms_pkg.sv
// Shared constants and types for the test access port with mode strap
package jtbms_pkg;
  // Test controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SH_DR   = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } jtbms_state_t;
  // Instruction register layout
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_RESET_VAL = 4'hf;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // Stages in each pin synchroniser
  localparam int SYNC_STAGES = 2;
  // Rises with mode select high that always reach test-logic-reset
  localparam logic [2:0] RESET_RISES = 3'h5;
endpackage : jtbms_pkg

// ===== core/jtbms_top.sv
// Test access port controller, bypass path and boundary-scan/debug mode select
// Operation
// - With bypass instruction active, one shift stage sits between data in and out.
// - All test state is held in flops; a stopped test clock loses nothing.
// - Test reset pin low forces and holds the controller in test-logic-reset.
// - Five test-clock rises with mode select high reach test-logic-reset on the fifth rise.
// - Mode strap sampled at reset: low gives debug mode, high allows boundary scan.
// - Debug mode holds the controller in test-logic-reset internally.
// - Debug mode reroutes data in, mode select and test reset to debug functions.
`timescale 1ns/100ps
`default_nettype none
module jtbms_top
  import jtbms_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  input wire logic i_test_mode_strap,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_debug_mode,
  output logic o_debug_serial_in,
  output logic o_breakpoint_request,
  output logic o_debug_serial_clock,
  output logic o_tap_reset
);

  // Two-flop synchronisers for all pins; first stage feeds only the second
  logic [4:0] sync1_reg, sync1_next;
  logic [4:0] sync2_reg, sync2_next;
  logic tck_prev_reg, tck_prev_next;
  logic tck_s, tms_s, tdi_s, trst_n_s, strap_s;
  logic tck_rise, tck_fall;

  always_comb
  begin
    sync1_next = {i_test_mode_strap, i_trst_n, i_tdi, i_tms, i_tck};
    sync2_next = sync1_reg;
    tck_prev_next = sync2_reg[0];
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_reg <= 5'h0c;
      sync2_reg <= 5'h0c;
      tck_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      tck_prev_reg <= tck_prev_next;
    end
  end

  assign tck_s = sync2_reg[0];
  assign tms_s = sync2_reg[1];
  assign tdi_s = sync2_reg[2];
  assign trst_n_s = sync2_reg[3];
  assign strap_s = sync2_reg[4];
  // Edges found by the system clock; test clock must be slower than a quarter of it
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  // Strap capture: taken in the first cycles after release, once the synchroniser is full
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic debug_reg, debug_next;

  always_comb
  begin
    strap_cnt_next = strap_cnt_reg;
    debug_next = debug_reg;
    if (strap_cnt_reg != 2'h3)
    begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2)
        debug_next = ~strap_s;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      strap_cnt_reg <= 2'h0;
      debug_reg <= 1'b0;
    end
    else
    begin
      strap_cnt_reg <= strap_cnt_next;
      debug_reg <= debug_next;
    end
  end

  // Controller reset: pin, debug mode, or strap not yet taken
  logic tap_rst;
  assign tap_rst = ~trst_n_s | debug_reg | (strap_cnt_reg != 2'h3);

  // Test controller and data path; everything is in flops, so a halted clock is harmless
  jtbms_state_t state_reg, state_next;
  logic [IR_WIDTH-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
  logic byp_reg, byp_next;
  logic tdo_reg, tdo_next;
  logic tdo_oe_reg, tdo_oe_next;

  always_comb
  begin
    state_next = state_reg;
    ir_sh_next = ir_sh_reg;
    ir_next = ir_reg;
    byp_next = byp_reg;
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tap_rst)
    begin
      state_next = ST_RESET;
      ir_next = IR_RESET_VAL;
      tdo_oe_next = 1'b0;
    end
    else if (tck_rise)
    begin
      unique case (state_reg)
        ST_RESET:  state_next = tms_s ? ST_RESET : ST_IDLE;
        ST_IDLE:   state_next = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: state_next = tms_s ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: state_next = tms_s ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: state_next = tms_s ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: state_next = tms_s ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
        default:   state_next = ST_RESET;
      endcase
      // Data path acts in the state being left
      if (state_reg == ST_CAP_IR)
        ir_sh_next = {{(IR_WIDTH-2){1'b0}}, IR_CAPTURE};
      else if (state_reg == ST_SH_IR)
        ir_sh_next = {tdi_s, ir_sh_reg[IR_WIDTH-1:1]};
      if (state_reg == ST_CAP_DR)
        byp_next = 1'b0;
      else if (state_reg == ST_SH_DR)
        byp_next = tdi_s;
      if (state_reg == ST_RESET)
        ir_next = IR_RESET_VAL;
      else if (state_reg == ST_UPD_IR)
        ir_next = ir_sh_reg;
    end
    else if (tck_fall)
    begin
      // Output updates on each falling test-clock edge outside controller reset; the enable is set only while shifting
      tdo_oe_next = (state_reg == ST_SH_DR) | (state_reg == ST_SH_IR);
      if (state_reg == ST_SH_IR)
        tdo_next = ir_sh_reg[0];
      else
        tdo_next = byp_reg; // All data instructions use the bypass stage here
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= ST_RESET;
      ir_sh_reg <= '0;
      ir_reg <= IR_RESET_VAL;
      byp_reg <= 1'b0;
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg <= ir_next;
      byp_reg <= byp_next;
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  // Debug rerouting; pins read as idle outside debug mode
  logic dbg_in_reg, dbg_in_next, breakpoint_request_reg, breakpoint_request_next, dclk_reg, dclk_next;

  always_comb
  begin
    dbg_in_next = debug_reg & tdi_s;
    breakpoint_request_next = debug_reg & tms_s;
    dclk_next = debug_reg & trst_n_s;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dbg_in_reg <= 1'b0;
      breakpoint_request_reg <= 1'b0;
      dclk_reg <= 1'b0;
    end
    else
    begin
      dbg_in_reg <= dbg_in_next;
      breakpoint_request_reg <= breakpoint_request_next;
      dclk_reg <= dclk_next;
    end
  end

  assign o_tdo = tdo_reg;
  assign o_tdo_oe = tdo_oe_reg;
  assign o_debug_mode = debug_reg;
  assign o_debug_serial_in = dbg_in_reg;
  assign o_breakpoint_request = breakpoint_request_reg;
  assign o_debug_serial_clock = dclk_reg;
  assign o_tap_reset = (state_reg == ST_RESET);

  // Consecutive rises with mode select high; only the five-rise check reads it, so it saturates
  logic [2:0] hi_rises_reg, hi_rises_next;

  always_comb
  begin
    hi_rises_next = hi_rises_reg;
    if (tap_rst || (tck_rise && !tms_s))
      hi_rises_next = 3'h0;
    else if (tck_rise && hi_rises_reg != RESET_RISES)
      hi_rises_next = hi_rises_reg + 3'h1;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      hi_rises_reg <= 3'h0;
    else
      hi_rises_reg <= hi_rises_next;
  end

  // A test-clock rise that the controller acts on, with mode select high or low
  sequence s_rise_high;
    tck_rise && tms_s && !tap_rst;
  endsequence
  sequence s_rise_low;
    tck_rise && !tms_s && !tap_rst;
  endsequence

  AST_RESET_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !trst_n_s |=> state_reg == ST_RESET)
    else $error("controller left reset while test reset low");
  AST_DEBUG_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    debug_reg |=> state_reg == ST_RESET && !tdo_oe_reg)
    else $error("controller active in debug mode");
  AST_STRAP: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    strap_cnt_reg == 2'h2 |=> debug_reg == !$past(strap_s))
    else $error("strap sampled wrongly");
  AST_STRAP_STABLE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    strap_cnt_reg == 2'h3 |=> $stable(debug_reg))
    else $error("mode changed after strap capture");
  AST_TMS_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_rise_high ##0 (state_reg == ST_SEL_IR) |=> state_reg == ST_RESET)
    else $error("select-ir with mode high did not reach reset");
  AST_FIVE_RISES: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    hi_rises_reg == RESET_RISES |-> state_reg == ST_RESET)
    else $error("five rises with mode high did not reach reset");
  AST_IDLE_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_rise_low ##0 (state_reg == ST_RESET) |=> state_reg == ST_IDLE)
    else $error("reset did not step to idle");
  AST_HALT: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !tck_rise && !tck_fall && !tap_rst |=> $stable(state_reg) && $stable(byp_reg) && $stable(ir_reg))
    else $error("state changed with test clock halted");
  AST_BYPASS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    tck_rise && !tap_rst && state_reg == ST_SH_DR |=> byp_reg == $past(tdi_s))
    else $error("bypass stage did not take data in");
  AST_BYP_OUT: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    tck_fall && !tap_rst && state_reg == ST_SH_DR |=> o_tdo == $past(byp_reg) && o_tdo_oe)
    else $error("bypass stage not driven out");
  AST_BREAKPOINT_REQUEST: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    debug_reg && $stable(debug_reg) |=> o_breakpoint_request == $past(tms_s)
      && o_debug_serial_clock == $past(trst_n_s) && o_debug_serial_in == $past(tdi_s))
    else $error("debug pins not rerouted");

endmodule : jtbms_top
`default_nettype wire

// ===== testbench/jtbms_tester.sv
// Board tester model that drives the test port pins and strobes data out
`timescale 1ns/100ps
`default_nettype none
module jtbms_tester
(
  input wire logic i_ref_clk,
  input wire logic i_tdo,
  output var logic o_tck,
  output var logic o_tms,
  output var logic o_tdi,
  output var logic o_trst_n
);
  logic tdo_seen;
  // Half a test-clock period is 5 reference cycles; offset so edges never meet the reference rise
  task automatic half();
    repeat (5) @(posedge i_ref_clk);
    #1;
  endtask : half
  // Static pin levels, also used for the debug functions of the pins
  task automatic pins(input logic tms, input logic tdi, input logic trst_n);
    o_tms = tms;
    o_tdi = tdi;
    o_trst_n = trst_n;
  endtask : pins
  // Pins change only while the test clock is low; data out strobed just before the rise
  task automatic rise(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    half();
    tdo_seen = i_tdo;
    o_tck = 1'b1;
    half();
  endtask : rise
  // Test clock is paced from the reference clock here, so both clocks are coordinated outside
  task automatic fall();
    o_tck = 1'b0;
  endtask : fall
  task automatic bit_cyc(input logic tms, input logic tdi);
    rise(tms, tdi);
    fall();
  endtask : bit_cyc
  // Five rises with mode select high reach test-logic-reset on the fifth rise; the fall and a half period follow
  task automatic reset_walk();
    repeat (5) bit_cyc(1'b1, 1'b0);
    half();
  endtask : reset_walk
  // Test clock stands low outside frames; other pins rest at their pull-up level
  initial
  begin
    o_tck = 1'b0;
    pins(1'b1, 1'b1, 1'b1);
  end
endmodule : jtbms_tester
`default_nettype wire

// ===== testbench/test_jtbms_top.sv
// Self-checking bench for the test port with bypass path and mode strap
`timescale 1ns/100ps
`default_nettype none
module test_jtbms_top;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic strap = 1'b1;
  logic tck, tms, tdi, trst_n;
  logic tdo, tdo_oe, dbg, dsi, breakpoint_request, debug_serial_clock, tap_rst;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [3:0] data = 4'hb;
  logic prev;
  // 125 MHz reference clock
  always #4 i_ref_clk = ~i_ref_clk;
  jtbms_top dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_trst_n(trst_n), .i_test_mode_strap(strap), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_debug_mode(dbg),
    .o_debug_serial_in(dsi), .o_breakpoint_request(breakpoint_request), .o_debug_serial_clock(debug_serial_clock), .o_tap_reset(tap_rst));
  jtbms_tester tester_u (.i_ref_clk(i_ref_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : check
  // Reset held 3 cycles; strap settles before release and stays put
  task automatic do_reset(input logic strap_v);
    @(posedge i_ref_clk) #1;
    i_arst_n = 1'b0;
    strap = strap_v;
    repeat (3) @(posedge i_ref_clk);
    #1;
    i_arst_n = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask : do_reset
  task automatic t_reset_state();
    check("tap_reset", 1'b1, tap_rst);
    check("debug_mode", 1'b0, dbg);
    check("tdo_oe", 1'b0, tdo_oe);
  endtask : t_reset_state
  // Walk to shift-dr, shift 1,1,0,1: each bit returns one test clock later, capture 0 first
  task automatic t_bypass();
    tester_u.bit_cyc(1'b0, 1'b1);
    tester_u.bit_cyc(1'b1, 1'b1);
    tester_u.bit_cyc(1'b0, 1'b1);
    tester_u.bit_cyc(1'b0, 1'b1);
    prev = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      tester_u.bit_cyc(1'b0, data[i]);
      check("bypass_tdo", prev, tester_u.tdo_seen);
      check("tdo_oe", 1'b1, tdo_oe);
      check("tap_reset", 1'b0, tap_rst);
      prev = data[i];
    end
  endtask : t_bypass
  // Stop the test clock high, then low, for a long time; the stage keeps its bit
  task automatic t_static();
    tester_u.rise(1'b0, 1'b0);
    repeat (2000) @(posedge i_ref_clk);
    check("tdo_held_high", prev, tdo);
    tester_u.fall();
    tester_u.half();
    repeat (2000) @(posedge i_ref_clk);
    check("tdo_held_low", 1'b0, tdo);
    tester_u.bit_cyc(1'b1, 1'b1);
    check("bypass_tdo", 1'b0, tester_u.tdo_seen);
    tester_u.half();
    check("tdo_oe", 1'b0, tdo_oe);
  endtask : t_static
  // Walk to shift-ir: the capture pattern comes out first bit first, then back to idle
  task automatic t_ir();
    logic [3:0] cap;
    cap = 4'(jtbms_pkg::IR_CAPTURE);
    tester_u.bit_cyc(1'b0, 1'b1);
    tester_u.bit_cyc(1'b1, 1'b1);
    tester_u.bit_cyc(1'b1, 1'b1);
    tester_u.bit_cyc(1'b0, 1'b1);
    tester_u.bit_cyc(1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      tester_u.bit_cyc(i == 3, 1'b1);
      check("ir_capture_tdo", cap[i], tester_u.tdo_seen);
      check("tdo_oe", 1'b1, tdo_oe);
    end
    tester_u.bit_cyc(1'b1, 1'b0);
    tester_u.bit_cyc(1'b0, 1'b0);
    check("tap_reset", 1'b0, tap_rst);
    check("tdo_oe", 1'b0, tdo_oe);
  endtask : t_ir
  task automatic t_five();
    tester_u.reset_walk();
    check("tap_reset", 1'b1, tap_rst);
  endtask : t_five
  // Test reset low wins over clocking with mode select low
  task automatic t_trst();
    tester_u.bit_cyc(1'b0, 1'b0);
    tester_u.half();
    check("tap_reset", 1'b0, tap_rst);
    tester_u.pins(1'b0, 1'b0, 1'b0);
    tester_u.half();
    check("tap_reset", 1'b1, tap_rst);
    repeat (3) tester_u.bit_cyc(1'b0, 1'b0);
    check("tap_reset", 1'b1, tap_rst);
    tester_u.pins(1'b1, 1'b1, 1'b1);
  endtask : t_trst
  // Strap low at reset: controller held in reset and pins rerouted
  task automatic t_debug();
    do_reset(1'b0);
    check("debug_mode", 1'b1, dbg);
    repeat (3) tester_u.bit_cyc(1'b0, 1'b0);
    check("tap_reset", 1'b1, tap_rst);
    for (int v = 0; v < 2; v++)
    begin
      tester_u.pins(v[0], v[0], ~v[0]);
      tester_u.half();
      check("debug_serial_in", v[0], dsi);
      check("breakpoint_request", v[0], breakpoint_request);
      check("debug_serial_clock", ~v[0], debug_serial_clock);
    end
    tester_u.pins(1'b1, 1'b1, 1'b1);
    do_reset(1'b1);
    check("debug_mode", 1'b0, dbg);
    check("debug_serial_in", 1'b0, dsi);
  endtask : t_debug
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    do_reset(1'b1);
    t_reset_state();
    t_bypass();
    t_static();
    t_five();
    t_ir();
    t_trst();
    t_debug();
    wrap_up();
  end
endmodule : test_jtbms_top
`default_nettype wire
